/* File: logic/rcc_axil_slave.sv */
`timescale 1ns/1ps
// axi4-lite slave turning bus transfers into register strobes
module rcc_axil_slave import rcc_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write address channel
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// write data channel
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// write response channel
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// read address channel
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// read data channel
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// strobes to the register file
	rcc_regbus_if.bus_end regs
);

	// whole slave state
	typedef struct packed {
		logic aw_full; // write address held
		logic [7:0] aw_addr;
		logic w_full; // write data held
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rcc_axi_state_t;

	rcc_axi_state_t st_reg;
	rcc_axi_state_t st_next;

	// ready terms: one item per channel is buffered, no new read while data waits
	assign s_axi_awready = !st_reg.aw_full;
	assign s_axi_wready = !st_reg.w_full;
	assign s_axi_arready = !st_reg.rvalid;
	assign s_axi_bvalid = st_reg.bvalid;
	assign s_axi_bresp = st_reg.bresp;
	assign s_axi_rvalid = st_reg.rvalid;
	assign s_axi_rdata = st_reg.rdata;
	assign s_axi_rresp = st_reg.rresp;

	// write fires once address and data are both held and no response waits
	assign regs.wr_en = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
	assign regs.wr_addr = st_reg.aw_addr;
	assign regs.wr_data = st_reg.w_data;
	assign regs.wr_strb = st_reg.w_strb;
	// read fires on the address handshake itself
	assign regs.rd_en = s_axi_arvalid && !st_reg.rvalid;
	assign regs.rd_addr = s_axi_araddr;

	// next-state of both directions
	always_comb begin
		st_next = st_reg;
		// capture write address
		if (s_axi_awvalid && !st_reg.aw_full) begin
			st_next.aw_full = 1'b1;
			st_next.aw_addr = s_axi_awaddr;
		end
		// capture write data
		if (s_axi_wvalid && !st_reg.w_full) begin
			st_next.w_full = 1'b1;
			st_next.w_data = s_axi_wdata;
			st_next.w_strb = s_axi_wstrb;
		end
		// retire a taken response
		if (st_reg.bvalid && s_axi_bready) begin
			st_next.bvalid = 1'b0;
		end
		// perform the write and raise its response
		if (regs.wr_en) begin
			st_next.aw_full = 1'b0;
			st_next.w_full = 1'b0;
			st_next.bvalid = 1'b1;
			st_next.bresp = regs.wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		// retire taken read data
		if (st_reg.rvalid && s_axi_rready) begin
			st_next.rvalid = 1'b0;
		end
		// latch read data into the output register
		if (regs.rd_en) begin
			st_next.rvalid = 1'b1;
			st_next.rdata = regs.rd_data;
			st_next.rresp = regs.rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
	end

	// state register, synchronous reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

endmodule

/* File: logic/rcc_reset_combiner.sv */
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - merge all sources into one system reset
// - accept eight reset source kinds
// - illegal category from four separate causes
// - any active source asserts system reset
// - reset forces some registers, leaves others
// - each reset sets its own cause bit
// - power-on clears causes, sets bits one, zero
// - software may set or clear cause bits
// - writing cause bits never starts a reset
// - every reset reloads oscillator control from configuration
module rcc_reset_combiner import rcc_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// asynchronous sources: supply monitors and the clear pin
	input wire logic power_on_reset,
	input wire logic brown_out_reset,
	input wire logic ext_clear_pin_reset_n,
	// synchronous sources from the core
	input wire logic software_reset_instr,
	input wire logic watchdog_timeout_reset,
	input wire logic config_mismatch_reset,
	input wire logic trap_conflict_reset,
	// illegal condition causes from the core
	input wire logic illegal_opcode,
	input wire logic uninit_wreg_use,
	input wire logic security_violation,
	input wire logic illegal_addr_mode,
	// clock selection from the oscillator configuration word
	input wire logic [2:0] initial_osc_select_bits,
	// outputs to the chip
	output logic master_system_reset,
	output logic [2:0] osc_control_register,
	output logic irq
);

	// whole block state
	typedef struct packed {
		logic [2:0] meta; // first synchroniser stage, read only by sync
		logic [2:0] sync; // second stage: {clear pin, brown-out, power-on}
		logic [7:0] src_prev; // source levels one cycle ago
		logic [7:0] cause; // reset cause register
		logic [7:0] irq_stat; // sticky source-onset events
		logic [7:0] irq_mask; // interrupt enables
		logic [2:0] osc; // oscillator control register
		logic boot_done; // oscillator loaded after bring-up
		logic sys_rst; // master system reset
		logic irq; // interrupt level
	} rcc_core_t;

	rcc_core_t st_reg;
	rcc_core_t st_next;

	// carrier between the axi slave and this register file
	rcc_regbus_if regbus ();

	// combined illegal condition and per-cause source vector
	logic illegal_condition_reset;
	logic [7:0] src_now;
	logic [7:0] src_onset;
	// decoded register writes and reads
	logic wr_lane0;
	logic wr_cause;
	logic wr_osc;
	logic wr_mask;
	logic rd_irq_stat;

	// bus protocol lives in its own module
	rcc_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regs(regbus.bus_end)
	);

	// any of the four faults raises the illegal condition category
	assign illegal_condition_reset = illegal_opcode | uninit_wreg_use | security_violation | illegal_addr_mode;

	// gather all sources in cause-register order; only synchronised copies of pins are used
	always_comb begin
		src_now = '0;
		src_now[BIT_POR] = st_reg.sync[0];
		src_now[BIT_BROWN] = st_reg.sync[1];
		src_now[BIT_EXT] = !st_reg.sync[2];
		src_now[BIT_SOFT] = software_reset_instr;
		src_now[BIT_WDT] = watchdog_timeout_reset;
		src_now[BIT_CFG] = config_mismatch_reset;
		src_now[BIT_TRAP] = trap_conflict_reset;
		src_now[BIT_ILL] = illegal_condition_reset;
	end

	// a source going active is an interrupt event
	assign src_onset = src_now & ~st_reg.src_prev;

	// write decode; all fields live in byte lane zero
	assign wr_lane0 = regbus.wr_en && regbus.wr_strb[0];
	assign wr_cause = wr_lane0 && (regbus.wr_addr == OFS_CAUSE);
	assign wr_osc = wr_lane0 && (regbus.wr_addr == OFS_OSC);
	assign wr_mask = wr_lane0 && (regbus.wr_addr == OFS_IRQ_MASK);
	// read decode for the clear-on-read status
	assign rd_irq_stat = regbus.rd_en && (regbus.rd_addr == OFS_IRQ_STAT);

	// mapped offsets answer okay, others an error
	assign regbus.wr_ok = reg_mapped(regbus.wr_addr);
	assign regbus.rd_ok = reg_mapped(regbus.rd_addr);

	// read data mux, upper bits read as zero
	always_comb begin
		regbus.rd_data = '0;
		unique case (regbus.rd_addr)
			OFS_CAUSE: begin
				regbus.rd_data[7:0] = st_reg.cause;
			end
			OFS_OSC: begin
				regbus.rd_data[2:0] = st_reg.osc;
			end
			OFS_IRQ_STAT: begin
				regbus.rd_data[7:0] = st_reg.irq_stat;
			end
			OFS_IRQ_MASK: begin
				regbus.rd_data[7:0] = st_reg.irq_mask;
			end
			OFS_SRC_LVL: begin
				// live view of the sources
				regbus.rd_data[7:0] = src_now;
			end
			default: begin
				// unmapped offsets read zero with an error response
				regbus.rd_data = '0;
			end
		endcase
	end

	// next state of the whole block
	always_comb begin
		st_next = st_reg;

		// two-stage synchronisers for the asynchronous inputs
		st_next.meta = {ext_clear_pin_reset_n, brown_out_reset, power_on_reset};
		st_next.sync = st_reg.meta;
		st_next.src_prev = src_now;

		// system reset follows the or of every source, never the cause bits
		st_next.sys_rst = |src_now;

		// software may write any cause bit
		if (wr_cause) begin
			st_next.cause = regbus.wr_data[7:0];
		end
		// hardware sets win over a software write in the same cycle
		if (src_now[BIT_POR]) begin
			// power-on leaves only the power-on and brown-out flags
			st_next.cause = CAUSE_POR_VAL;
		end else begin
			// other resets add their own bit and keep the rest
			st_next.cause = st_next.cause | src_now;
		end

		// oscillator control reloads on every reset and once after bring-up
		if (!st_reg.boot_done || (|src_now)) begin
			st_next.osc = initial_osc_select_bits;
			st_next.boot_done = 1'b1;
		end else if (wr_osc) begin
			// software clock switching between resets
			st_next.osc = regbus.wr_data[2:0];
		end

		// interrupt mask is plain storage, kept across system resets
		if (wr_mask) begin
			st_next.irq_mask = regbus.wr_data[7:0];
		end

		// sticky status cleared by reading it; a new event in that cycle survives
		if (rd_irq_stat) begin
			st_next.irq_stat = '0;
		end
		st_next.irq_stat = st_next.irq_stat | src_onset;

		// level interrupt while any enabled status bit is set
		st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
	end

	// state register; reset is treated as a power-on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_reg.meta <= PIN_SYNC_RST;
			st_reg.sync <= PIN_SYNC_RST;
			st_reg.src_prev <= '0;
			st_reg.cause <= CAUSE_RST;
			st_reg.irq_stat <= IRQ_STAT_RST;
			st_reg.irq_mask <= IRQ_MASK_RST;
			st_reg.osc <= OSC_RST;
			st_reg.boot_done <= 1'b0;
			st_reg.sys_rst <= 1'b1;
			st_reg.irq <= 1'b0;
		end else begin
			st_reg <= st_next;
		end
	end

	// outputs straight from flip-flops
	assign master_system_reset = st_reg.sys_rst;
	assign osc_control_register = st_reg.osc;
	assign irq = st_reg.irq;

endmodule

/* File: shared/rcc_pkg.sv */
// shared constants and helpers for the reset cause combiner
package rcc_pkg;

	// register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register byte offsets
	localparam logic [7:0] OFS_CAUSE = 8'h00;
	localparam logic [7:0] OFS_OSC = 8'h04;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
	localparam logic [7:0] OFS_SRC_LVL = 8'h10;

	// reset cause field positions, shared by cause, status, mask and level registers
	localparam int unsigned BIT_BROWN = 0;
	localparam int unsigned BIT_POR = 1;
	localparam int unsigned BIT_ILL = 2;
	localparam int unsigned BIT_CFG = 3;
	localparam int unsigned BIT_WDT = 4;
	localparam int unsigned BIT_SOFT = 5;
	localparam int unsigned BIT_EXT = 6;
	localparam int unsigned BIT_TRAP = 7;
	localparam int unsigned CAUSE_W = 8;
	localparam int unsigned OSC_W = 3;

	// values after reset
	localparam logic [7:0] CAUSE_POR_VAL = 8'h03;
	localparam logic [7:0] CAUSE_RST = 8'h03;
	localparam logic [7:0] IRQ_STAT_RST = 8'h00;
	localparam logic [7:0] IRQ_MASK_RST = 8'h00;
	localparam logic [2:0] OSC_RST = 3'h0;
	localparam logic [2:0] PIN_SYNC_RST = 3'h4;

	// axi response codes
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// true when an offset names an implemented register
	function automatic logic reg_mapped(input logic [7:0] addr);
		return (addr == OFS_CAUSE) || (addr == OFS_OSC) || (addr == OFS_IRQ_STAT) ||
			(addr == OFS_IRQ_MASK) || (addr == OFS_SRC_LVL);
	endfunction

endpackage

/* File: shared/rcc_regbus_if.sv */
`timescale 1ns/1ps
// register access strobes between the axi slave and the register file
interface rcc_regbus_if;
	logic wr_en; // one-cycle write strobe
	logic [7:0] wr_addr; // write byte offset
	logic [31:0] wr_data; // write data
	logic [3:0] wr_strb; // write byte lanes
	logic wr_ok; // write offset is mapped
	logic rd_en; // one-cycle read strobe
	logic [7:0] rd_addr; // read byte offset
	logic [31:0] rd_data; // read data, valid with rd_en
	logic rd_ok; // read offset is mapped

	// axi side drives the strobes
	modport bus_end (
		output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_ok, rd_data, rd_ok
	);

	// register file answers them
	modport reg_end (
		input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_ok, rd_data, rd_ok
	);
endinterface

/* File: test/rcc_reset_combiner_properties.sv */
`timescale 1ns/1ps
// watches the combiner ports: reset output, clock reload, read channel
module rcc_rst_props import rcc_pkg::*; (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// reset sources and the oscillator configuration word
	input wire logic power_on_reset,
	input wire logic brown_out_reset,
	input wire logic ext_clear_pin_reset_n,
	input wire logic software_reset_instr,
	input wire logic watchdog_timeout_reset,
	input wire logic config_mismatch_reset,
	input wire logic trap_conflict_reset,
	input wire logic illegal_opcode,
	input wire logic uninit_wreg_use,
	input wire logic security_violation,
	input wire logic illegal_addr_mode,
	input wire logic [2:0] initial_osc_select_bits,
	// outputs
	input wire logic master_system_reset,
	input wire logic [2:0] osc_control_register,
	input wire logic irq,
	// read channel
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// same-clock sources with the illegal causes folded in
	wire core_src = software_reset_instr | watchdog_timeout_reset | config_mismatch_reset |
		trap_conflict_reset | illegal_opcode | uninit_wreg_use | security_violation | illegal_addr_mode;
	// pin sources ahead of their synchronisers
	wire pin_src = power_on_reset | brown_out_reset | !ext_clear_pin_reset_n;
	// read address taken at this edge
	wire ar_take = s_axi_arvalid & s_axi_arready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_core_src_rst: assert property (core_src |=> master_system_reset)
		else $error("system reset missed a core source");
	a_pin_src_rst: assert property (pin_src |-> ##3 master_system_reset)
		else $error("system reset missed a pin source");
	a_idle_no_rst: assert property ((!core_src && !pin_src) [*4] |=> !master_system_reset)
		else $error("system reset without a source");
	a_osc_reload: assert property (core_src |=> osc_control_register == $past(initial_osc_select_bits))
		else $error("clock control not reloaded");
	a_stat_read_clr: assert property (((!core_src && !pin_src) [*3] ##0 (ar_take && s_axi_araddr == OFS_IRQ_STAT))
		|-> ##[1:3] !irq)
		else $error("interrupt stayed up after status read");
	a_rd_answer: assert property (ar_take |=> s_axi_rvalid)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answer pending");
	c_rst_rise: cover property ($rose(master_system_reset));
	c_irq_up: cover property ($rose(irq));
	c_stat_read: cover property (ar_take && s_axi_araddr == OFS_IRQ_STAT);
endmodule

/* File: test/rcc_src_model.sv */
`timescale 1ns/1ps
// on-chip reset sources: holds one chosen source high for a set count
module rcc_src_model (
	// clock
	input wire logic aclk,
	// request from the bench
	input wire logic kick,
	input wire logic [3:0] sel,
	input wire logic [3:0] len,
	// one active-high line per source
	output logic [10:0] src
);
	logic [3:0] left_reg = 4'h0; // cycles still to hold
	logic [3:0] sel_reg = 4'h0; // source being held
	// load on a request, then count down
	always @(posedge aclk) begin
		if (kick) begin
			left_reg <= len;
			sel_reg <= sel;
		end else if (left_reg != 4'h0) begin
			left_reg <= left_reg - 4'h1;
		end
	end
	// every source and every illegal cause has its own line
	assign src = (left_reg != 4'h0) ? (11'h1 << sel_reg) : 11'h0;
endmodule

/* File: test/tb.sv */
`timescale 1ns/1ps
// top bench: register traffic plus reset source pulses
module tb import rcc_pkg::*;;
	logic aclk = 1'b0, aresetn = 1'b0; // clock and bus reset
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, msr, irq; // design outputs
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, cause;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0] bresp, rresp;
	logic [2:0] cfg = 3'h0, osc;
	logic kick = 1'b0;
	logic [3:0] wstrb = 4'hf; // write byte lanes
	logic [1:0] expb_q[$]; // expected write responses
	logic [3:0] sel = 4'h0, len = 4'h1;
	logic [10:0] src; // source lines from the model
	logic [33:0] exp_q[$]; // expected read answers, response over data
	logic [7:0] bit_of [11] = '{8'h02, 8'h01, 8'h40, 8'h20, 8'h10, 8'h08, 8'h80, 8'h04, 8'h04, 8'h04, 8'h04};
	int err_total = 0, n_compared = 0, cyc = 0;
	always #20 aclk = ~aclk;
	rcc_src_model u_src (.aclk(aclk), .kick(kick), .sel(sel), .len(len), .src(src));
	rcc_reset_combiner DUT (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.power_on_reset(src[0]), .brown_out_reset(src[1]), .ext_clear_pin_reset_n(!src[2]),
		.software_reset_instr(src[3]), .watchdog_timeout_reset(src[4]), .config_mismatch_reset(src[5]),
		.trap_conflict_reset(src[6]), .illegal_opcode(src[7]), .uninit_wreg_use(src[8]),
		.security_violation(src[9]), .illegal_addr_mode(src[10]), .initial_osc_select_bits(cfg),
		.master_system_reset(msr), .osc_control_register(osc), .irq(irq)
	);
	// compare one value and count it
	task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] want);
		n_compared++;
		if (seen !== want) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, want, seen);
		end
	endtask
	// print the counts and the verdict, then stop
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// one register write, address and data offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] resp = RESP_OKAY);
		logic ta, tw, tr;
		expb_q.push_back(resp);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tr = bready & bvalid;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) bready <= 1'b0;
		end while (!tr);
	endtask
	// one register read; the answer is noted for the monitor
	// lag keeps rready low for that many cycles so the answer must stand
	task automatic rd(input logic [7:0] a, input logic [33:0] want, input int lag = 0);
		logic ta, tr;
		exp_q.push_back(want);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= (lag == 0);
		do begin
			@(negedge aclk);
			ta = arvalid & arready;
			tr = rready & rvalid;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
			if (tr) begin
				rready <= 1'b0;
			end else if (lag > 0) begin
				lag--;
				if (lag == 0) rready <= 1'b1;
			end
		end while (!tr);
	endtask
	// raise one source for a random length and let it settle
	task automatic fire(input int s);
		@(posedge aclk);
		kick <= 1'b1;
		sel <= 4'(s);
		len <= 4'($urandom_range(8, 1));
		@(posedge aclk);
		kick <= 1'b0;
		repeat (14) @(posedge aclk);
	endtask
	// each read answer against the oldest note
	always @(posedge aclk) begin
		if (rvalid === 1'b1 && rready === 1'b1) begin
			if (exp_q.size() == 0) chk("spare read", 34'h0, 34'h1);
			else chk("read", {rresp, rdata}, exp_q.pop_front());
		end
	end
	// each write response against the oldest note
	always @(posedge aclk) begin
		if (bvalid === 1'b1 && bready === 1'b1) begin
			if (expb_q.size() == 0) chk("spare write", 34'h0, 34'h1);
			else chk("write resp", {32'h0, bresp}, {32'h0, expb_q.pop_front()});
		end
	end
	// cuts a hang short
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			wrap_up();
		end
	end
	// main sequence
	initial begin
		void'($urandom(21));
		cfg <= 3'($urandom);
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		rd(OFS_CAUSE, {RESP_OKAY, 24'h0, CAUSE_RST});
		rd(OFS_OSC, {RESP_OKAY, 29'h0, cfg});
		rd(OFS_IRQ_MASK, {RESP_OKAY, 24'h0, IRQ_MASK_RST});
		wr(OFS_CAUSE, 32'h0);
		rd(OFS_CAUSE, {RESP_OKAY, 32'h0});
		cause = 8'h00;
		for (int s = 1; s < 11; s++) begin
			wr(OFS_IRQ_MASK, s[0] ? 32'hff : 32'h0);
			wr(OFS_OSC, {29'h0, ~cfg});
			rd(OFS_OSC, {RESP_OKAY, 29'h0, ~cfg}, 2);
			fire(s);
			cause = cause | bit_of[s];
			chk("irq", {33'h0, irq}, {33'h0, s[0]});
			chk("reset out", {33'h0, msr}, 34'h0);
			chk("osc pin", {31'h0, osc}, {31'h0, cfg});
			rd(OFS_CAUSE, {RESP_OKAY, 24'h0, cause});
			rd(OFS_OSC, {RESP_OKAY, 29'h0, cfg});
			rd(OFS_IRQ_STAT, {RESP_OKAY, 24'h0, bit_of[s]});
			rd(OFS_IRQ_STAT, {RESP_OKAY, 32'h0});
		end
		wr(OFS_CAUSE, 32'hf0);
		fire(0);
		rd(OFS_CAUSE, {RESP_OKAY, 24'h0, CAUSE_POR_VAL});
		wr(OFS_CAUSE, 32'hff);
		repeat (4) @(posedge aclk);
		chk("reset out", {33'h0, msr}, 34'h0);
		wstrb <= 4'he;
		wr(OFS_CAUSE, 32'h0);
		wstrb <= 4'hf;
		rd(OFS_CAUSE, {RESP_OKAY, 24'h0, 8'hff});
		rd(OFS_SRC_LVL, {RESP_OKAY, 32'h0});
		wr(8'h14, 32'h0, RESP_SLVERR);
		rd(8'h14, {RESP_SLVERR, 32'h0});
		wrap_up();
	end
endmodule
bind rcc_reset_combiner rcc_rst_props u_props (.aclk(aclk), .aresetn(aresetn),
	.power_on_reset(power_on_reset), .brown_out_reset(brown_out_reset),
	.ext_clear_pin_reset_n(ext_clear_pin_reset_n), .software_reset_instr(software_reset_instr),
	.watchdog_timeout_reset(watchdog_timeout_reset), .config_mismatch_reset(config_mismatch_reset),
	.trap_conflict_reset(trap_conflict_reset), .illegal_opcode(illegal_opcode),
	.uninit_wreg_use(uninit_wreg_use), .security_violation(security_violation),
	.illegal_addr_mode(illegal_addr_mode), .initial_osc_select_bits(initial_osc_select_bits),
	.master_system_reset(master_system_reset), .osc_control_register(osc_control_register), .irq(irq),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
